// ### mks_pkg.sv
// constants shared by the matrix keypad scanner files
package mks_pkg;

  // register byte offsets
  localparam logic [7:0] MKS_OFS_CONFIG = 8'h00;
  localparam logic [7:0] MKS_OFS_SCANOUT = 8'h04;
  localparam logic [7:0] MKS_OFS_VALUE0 = 8'h0c;
  localparam logic [7:0] MKS_OFS_VALUE1 = 8'h10;
  localparam logic [7:0] MKS_OFS_STATUS = 8'h18;
  localparam logic [7:0] MKS_OFS_MASK = 8'h1c;
  localparam logic [7:0] MKS_OFS_COLGPIO = 8'h20;

  // key_config_register fields
  localparam int MKS_CFG_RUN_BIT = 7;
  localparam int MKS_CFG_SLEEP_N_BIT = 2;
  localparam int MKS_CFG_RATE_LSB = 0;

  // key_status_register fields
  localparam int MKS_ST_DONE_BIT = 0;
  localparam int MKS_ST_IDLE_BIT = 1;

  // value register field positions, one 6-bit row group per column
  localparam int MKS_V0_C5_LSB = 24;
  localparam int MKS_V0_C4_LSB = 16;
  localparam int MKS_V0_C3_LSB = 8;
  localparam int MKS_V0_C2_LSB = 0;
  localparam int MKS_V1_C1_LSB = 8;
  localparam int MKS_V1_C0_LSB = 0;

  // reset values
  localparam logic [7:0] MKS_CONFIG_RST = 8'h00;
  localparam logic [1:0] MKS_STATUS_RST = 2'h0;
  localparam logic [1:0] MKS_MASK_RST = 2'h0;
  localparam logic [5:0] MKS_COLGPIO_RST = 6'h00;
  localparam logic [31:0] MKS_VALUE_RST = 32'h0000_0000;

  // scan_rate_select codes
  localparam logic [1:0] MKS_RATE_128 = 2'h1;
  localparam logic [1:0] MKS_RATE_256 = 2'h2;
  localparam logic [1:0] MKS_RATE_512 = 2'h3;

  // prescale_counter bit that forms scan_tick for each rate
  localparam int MKS_TICK_BIT_128 = 6;
  localparam int MKS_TICK_BIT_256 = 7;
  localparam int MKS_TICK_BIT_512 = 8;

  // timing counts in scan_tick cycles and slots
  localparam logic [4:0] MKS_COL_LAST = 5'd25;
  localparam logic [4:0] MKS_SAMP_A = 5'd8;
  localparam logic [4:0] MKS_SAMP_B = 5'd17;
  localparam logic [2:0] MKS_SLOT_LAST = 3'd7;
  localparam logic [2:0] MKS_SLOT_COLS = 3'd6;

endpackage

// ### mks_sync.sv
// three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/1ps
module mks_sync #(
  parameter int W = 6
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [W-1:0] d, // asynchronous pin levels
  output logic [W-1:0] q // filtered level
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] q_next;

  // a bit changes only when stages two and three agree
  assign q_next = (ff2_reg & ff3_reg) | (q & (ff2_reg | ff3_reg));

  // idle rows float high through their pull-ups
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1_reg <= {W{1'b1}};
      ff2_reg <= {W{1'b1}};
      ff3_reg <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      ff1_reg <= d;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      q <= q_next;
    end
  end

endmodule

// ### mks_top.sv
// matrix keypad scanner: column ring, row sampling, registers, interrupt
//
// Summary of operation
// - idle or reset: all columns driven low
// - idle row low sets wake flag, interrupts
// - scanning: at most one column low at once
// - eight slots: columns 5 down to 0, two empty
// - 9-bit prescaler counts, cleared asynchronously while the run bit is low
// - rate select picks divide by 128/256/512
// - each column lasts 26 scan ticks
// - two row samples; pressed only if both agree
// - low row stored as one, high as zero
// - columns map to fixed value register fields
// - end of scan sets done flag, interrupts
// - any nonzero status write clears both flags
// - run plus sleep bits start scanning immediately
// - general purpose columns are ignored, stored as zero
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module mks_top
  import mks_pkg::*;
(
  input wire logic SYS_CLK, // 25 MHz system clock
  input wire logic RST_N, // asynchronous reset, active low
  input wire logic [5:0] ROW_SENSE, // row sense pins, low when pressed
  output logic [5:0] COL_DRIVE, // column drive pins
  input wire logic [7:0] ADDR, // register byte address
  input wire logic [31:0] WR_DATA, // write data
  input wire logic WR_EN, // write strobe
  input wire logic RD_EN, // read strobe
  output logic [31:0] RD_DATA, // read data, cycle after the strobe
  output logic IRQ // keyboard interrupt, active high level
);

  // registers
  logic [7:0] config_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [5:0] colgpio_reg;
  logic [31:0] value0_reg;
  logic [31:0] value1_reg;
  logic [8:0] pre_reg;
  logic sel_prev_reg;
  logic [4:0] cnt_reg;
  logic [2:0] slot_reg;
  logic [5:0] samp_a_reg;
  logic [5:0] samp_b_reg;
  logic [5:0] col_reg;
  logic [31:0] rd_data_reg;
  logic irq_reg;

  // next values and decode
  logic [7:0] config_next;
  logic [1:0] status_next;
  logic [1:0] mask_next;
  logic [5:0] colgpio_next;
  logic [31:0] value0_next;
  logic [31:0] value1_next;
  logic [4:0] cnt_next;
  logic [2:0] slot_next;
  logic [5:0] col_next;
  logic [31:0] rd_mux;
  logic [5:0] row_sync;
  logic run_bit;
  logic sleep_n_bit;
  logic [1:0] rate_sel;
  logic scan_on;
  logic pre_clr_n;
  logic sel_bit;
  logic tick;
  logic col_wrap;
  logic scan_end;
  logic store_en;
  logic [5:0] slot_onehot;
  logic [5:0] next_onehot;
  logic col_ignored;
  logic [5:0] store_bits;
  logic idle_event;
  logic [1:0] status_set;
  logic status_clr;
  logic wr_config;
  logic wr_status;
  logic wr_mask;
  logic wr_colgpio;

  // row pins cross into the system clock domain
  mks_sync #(
    .W(6)
  ) u_row_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d(ROW_SENSE),
    .q(row_sync)
  );

  // configuration fields
  assign run_bit = config_reg[MKS_CFG_RUN_BIT];
  assign sleep_n_bit = config_reg[MKS_CFG_SLEEP_N_BIT];
  assign rate_sel = config_reg[MKS_CFG_RATE_LSB +: 2];
  assign scan_on = run_bit & sleep_n_bit;

  // register write decode
  assign wr_config = WR_EN & (ADDR == MKS_OFS_CONFIG);
  assign wr_status = WR_EN & (ADDR == MKS_OFS_STATUS);
  assign wr_mask = WR_EN & (ADDR == MKS_OFS_MASK);
  assign wr_colgpio = WR_EN & (ADDR == MKS_OFS_COLGPIO);

  // reserved configuration bits 6:3 always store zero
  assign config_next = wr_config ? (WR_DATA[7:0] & 8'h87) : config_reg;
  assign mask_next = wr_mask ? WR_DATA[1:0] : mask_reg;
  assign colgpio_next = wr_colgpio ? WR_DATA[5:0] : colgpio_reg;

  // prescaler is held clear while the run bit is low
  assign pre_clr_n = RST_N & run_bit;

  always_ff @(posedge SYS_CLK or negedge pre_clr_n) begin
    if (!pre_clr_n) begin
      pre_reg <= 9'h000;
      sel_prev_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 9'h001;
      sel_prev_reg <= sel_bit;
    end
  end

  // scan_tick is the rising edge of the selected prescaler bit
  assign sel_bit = (rate_sel == MKS_RATE_128) ? pre_reg[MKS_TICK_BIT_128] :
                   (rate_sel == MKS_RATE_256) ? pre_reg[MKS_TICK_BIT_256] :
                   (rate_sel == MKS_RATE_512) ? pre_reg[MKS_TICK_BIT_512] :
                   1'b0;
  assign tick = scan_on & sel_bit & ~sel_prev_reg;

  // column period and slot sequencing, cleared while idle
  assign col_wrap = tick & (cnt_reg == MKS_COL_LAST);
  assign scan_end = col_wrap & (slot_reg == MKS_SLOT_LAST);
  assign cnt_next = !scan_on ? 5'd0 :
                    col_wrap ? 5'd0 :
                    tick ? cnt_reg + 5'd1 : cnt_reg;
  assign slot_next = !scan_on ? 3'd0 :
                     col_wrap ? slot_reg + 3'd1 : slot_reg;

  // one-hot of the column that a slot drives low, column 5 first
  assign slot_onehot = (slot_reg < MKS_SLOT_COLS) ?
                       (6'h20 >> slot_reg) : 6'h00;
  assign next_onehot = (slot_next < MKS_SLOT_COLS) ?
                       (6'h20 >> slot_next) : 6'h00;

  // idle: all low; scanning: only the active keypad column low
  assign col_next = !scan_on ? 6'h00 :
                    (~next_onehot | colgpio_reg);

  // row results: low on both samples counts as pressed
  assign col_ignored = |(slot_onehot & colgpio_reg);
  assign store_bits = (~samp_a_reg & ~samp_b_reg) &
                      {6{~col_ignored}};
  assign store_en = col_wrap & (slot_reg < MKS_SLOT_COLS);

  // each column writes its own six-bit field
  always_comb begin
    value0_next = value0_reg;
    value1_next = value1_reg;
    if (store_en) begin
      unique case (slot_reg)
        3'd0: value0_next[MKS_V0_C5_LSB +: 6] = store_bits;
        3'd1: value0_next[MKS_V0_C4_LSB +: 6] = store_bits;
        3'd2: value0_next[MKS_V0_C3_LSB +: 6] = store_bits;
        3'd3: value0_next[MKS_V0_C2_LSB +: 6] = store_bits;
        3'd4: value1_next[MKS_V1_C1_LSB +: 6] = store_bits;
        3'd5: value1_next[MKS_V1_C0_LSB +: 6] = store_bits;
        default: value0_next = value0_reg;
      endcase
    end
  end

  // status events; a set in the clearing cycle survives
  assign idle_event = ~scan_on & (row_sync != 6'h3f);
  assign status_set = {idle_event, scan_end};
  assign status_clr = wr_status & (WR_DATA != 32'h0000_0000);
  assign status_next = (status_reg & ~{2{status_clr}}) | status_set;

  // read selection; unmapped addresses read zero
  assign rd_mux = (ADDR == MKS_OFS_CONFIG) ? {24'h000000, config_reg} :
                  (ADDR == MKS_OFS_SCANOUT) ? {26'h0000000, col_reg} :
                  (ADDR == MKS_OFS_VALUE0) ? value0_reg :
                  (ADDR == MKS_OFS_VALUE1) ? value1_reg :
                  (ADDR == MKS_OFS_STATUS) ? {30'h00000000, status_reg} :
                  (ADDR == MKS_OFS_MASK) ? {30'h00000000, mask_reg} :
                  (ADDR == MKS_OFS_COLGPIO) ? {26'h0000000, colgpio_reg} :
                  32'h0000_0000;

  // software registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      config_reg <= MKS_CONFIG_RST;
      status_reg <= MKS_STATUS_RST;
      mask_reg <= MKS_MASK_RST;
      colgpio_reg <= MKS_COLGPIO_RST;
      value0_reg <= MKS_VALUE_RST;
      value1_reg <= MKS_VALUE_RST;
    end else begin
      config_reg <= config_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      colgpio_reg <= colgpio_next;
      value0_reg <= value0_next;
      value1_reg <= value1_next;
    end
  end

  // scan sequencer and row samples
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg <= 5'd0;
      slot_reg <= 3'd0;
      samp_a_reg <= 6'h3f;
      samp_b_reg <= 6'h3f;
      col_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
      slot_reg <= slot_next;
      col_reg <= col_next;
      if (tick && cnt_reg == MKS_SAMP_A) begin
        samp_a_reg <= row_sync;
      end
      if (tick && cnt_reg == MKS_SAMP_B) begin
        samp_b_reg <= row_sync;
      end
    end
  end

  // read data and interrupt outputs
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_data_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      rd_data_reg <= RD_EN ? rd_mux : 32'h0000_0000;
      irq_reg <= |(status_next & mask_next);
    end
  end

  assign COL_DRIVE = col_reg;
  assign RD_DATA = rd_data_reg;
  assign IRQ = irq_reg;

  // checks on the column ring
  AST_IDLE_COLS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !scan_on ##1 !scan_on |-> col_reg == 6'h00)
    else $error("columns not all low while idle");

  AST_ONE_LOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    scan_on && $past(scan_on) |-> $countones(~col_reg) <= 1)
    else $error("more than one column low");

  AST_SLOT_MAP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    scan_on && $past(scan_on) |->
      col_reg == (~slot_onehot | $past(colgpio_reg)))
    else $error("wrong column for slot");

  AST_FRESH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(scan_on) |-> cnt_reg == 5'd0 && slot_reg == 3'd0
      ##1 (col_reg == (6'h1f | colgpio_reg)))
    else $error("scan did not restart at column five");

  // checks on prescaler and tick
  AST_PRESCALE_CLR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !run_bit |-> pre_reg == 9'h000)
    else $error("prescaler not cleared");

  AST_PRESCALE_INC: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    run_bit && $past(run_bit) |-> pre_reg == $past(pre_reg) + 9'h001)
    else $error("prescaler did not count");

  AST_TICK_RATE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    tick |-> (rate_sel == MKS_RATE_128 && pre_reg[6:0] == 7'h40) ||
             (rate_sel == MKS_RATE_256 && pre_reg[7:0] == 8'h80) ||
             (rate_sel == MKS_RATE_512 && pre_reg == 9'h100))
    else $error("tick at wrong prescaler value");

  // a column runs 26 ticks, then the slot advances
  sequence s_col_end;
    tick && cnt_reg == MKS_COL_LAST && scan_on;
  endsequence

  AST_COL_LEN: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_col_end |=> cnt_reg == 5'd0 &&
      slot_reg == $past(slot_reg) + 3'd1)
    else $error("column period length wrong");

  AST_STORE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_col_end and slot_reg == 3'd0) |=>
      value0_reg[29:24] == $past(~samp_a_reg & ~samp_b_reg &
        {6{~col_ignored}}))
    else $error("column five result not stored");

  // status flags
  AST_DONE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_col_end and slot_reg == MKS_SLOT_LAST) |=> status_reg[0])
    else $error("scan done flag not set");

  AST_IDLE_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !scan_on && row_sync != 6'h3f |=> status_reg[1])
    else $error("idle press flag not set");

  AST_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    status_clr && status_set == 2'h0 |=> status_reg == 2'h0)
    else $error("status write did not clear");

endmodule

// ### mks_keys.sv
// passive 6x6 key switch matrix with pull-ups on the row lines
`timescale 1ns/1ps
module mks_keys (
  input wire logic [5:0] col_drive, // column levels from the scanner
  input wire logic [35:0] key_map, // closed keys, index col*6+row
  output logic [5:0] row_sense // row levels, pulled high when open
);
  // a closed key on a low column pulls its row low, else pull-up
  always_comb begin
    row_sense = 6'h3f;
    for (int c = 0; c < 6; c++) begin
      for (int r = 0; r < 6; r++) begin
        if (key_map[c*6+r] && !col_drive[c]) begin
          row_sense[r] = 1'b0;
        end
      end
    end
  end
endmodule

// ### matrix_keypad_scanner_tb_top.sv
// self-checking bench for the matrix keypad scanner
`timescale 1ns/1ps
module matrix_keypad_scanner_tb_top
  import mks_pkg::*;
;
  localparam logic [31:0] RUN_CFG = 32'(1 << MKS_CFG_RUN_BIT) |
                                    32'(1 << MKS_CFG_SLEEP_N_BIT);
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] row_sense;
  logic [5:0] col_drive;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic irq;
  logic [35:0] key_map = 36'h0;
  int errors = 0;
  int total_checks = 0;

  // scanner and the key matrix it drives
  mks_top i_mks_top (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .ROW_SENSE(row_sense),
    .COL_DRIVE(col_drive), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .IRQ(irq)
  );
  mks_keys i_mks_keys (
    .col_drive(col_drive), .key_map(key_map), .row_sense(row_sense)
  );

  // 25 MHz clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    errors++;
    $display("MISMATCH %0t wait ran out", $time);
    give_verdict();
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // bounded wait for the interrupt or for a column pattern
  task automatic wait_for(input bit on_irq, input logic [5:0] p,
                          input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      if (on_irq ? irq === 1'b1 : col_drive === p) begin
        total_checks++;
        return;
      end
    end
    timed_out();
  endtask

  // reset values, unmapped read, idle wake flag and its clear
  task automatic t_idle();
    chk({26'h0, col_drive}, 32'h0);
    rchk(MKS_OFS_CONFIG, 32'h0);
    rchk(MKS_OFS_VALUE0, 32'h0);
    rchk(MKS_OFS_VALUE1, 32'h0);
    rchk(MKS_OFS_STATUS, 32'h0);
    rchk(8'h08, 32'h0);
    wr(MKS_OFS_MASK, 32'h2);
    key_map <= 36'h1 << 20; // column 3, row 2
    wait_for(1'b1, 6'h0, 20);
    rchk(MKS_OFS_STATUS, 32'h2);
    key_map <= 36'h0;
    repeat (10) @(posedge sys_clk);
    wr(MKS_OFS_STATUS, 32'h0);
    rchk(MKS_OFS_STATUS, 32'h2);
    wr(MKS_OFS_STATUS, 32'h4);
    rchk(MKS_OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  // length of the first column at one rate, then stop
  task automatic t_rate(input logic [1:0] code, input int div);
    int n;
    n = 0;
    wr(MKS_OFS_CONFIG, RUN_CFG | 32'(code));
    wait_for(1'b0, 6'h1f, 6);
    while (col_drive === 6'h1f && n < 30 * div) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(32'(n > 25 * div && n < 27 * div), 32'h1);
    chk({26'h0, col_drive}, 32'h2f);
    rchk(MKS_OFS_SCANOUT, 32'h2f);
    wr(MKS_OFS_CONFIG, 32'h0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({26'h0, col_drive}, 32'h0);
  endtask

  // reserved rate code gives no ticks, so column five stays low
  task automatic t_hold();
    wr(MKS_OFS_CONFIG, RUN_CFG);
    repeat (300) @(posedge sys_clk);
    rchk(MKS_OFS_SCANOUT, 32'h1f);
    rchk(MKS_OFS_CONFIG, RUN_CFG);
    wr(MKS_OFS_CONFIG, 32'h0);
  endtask

  // full scan with a masked column and a key closing between samples
  task automatic t_scan();
    logic [31:0] d;
    wr(MKS_OFS_COLGPIO, 32'h08);
    wr(MKS_OFS_MASK, 32'h1);
    key_map <= 36'h0_0421_2060;
    wr(MKS_OFS_CONFIG, RUN_CFG | 32'(MKS_RATE_128));
    wait_for(1'b0, 6'h1f, 6);
    repeat (1600) @(posedge sys_clk);
    key_map <= key_map | 36'h4000_0000; // column 5, row 0
    wait_for(1'b0, 6'h2f, 4000);
    wait_for(1'b0, 6'h3f, 4000);
    wait_for(1'b0, 6'h3b, 4000);
    wait_for(1'b0, 6'h3d, 4000);
    wait_for(1'b0, 6'h3e, 4000);
    wait_for(1'b1, 6'h0, 11000);
    rd(MKS_OFS_STATUS, d);
    chk(d & 32'h1, 32'h1);
    rchk(MKS_OFS_VALUE0, 32'h0004_0012);
    rchk(MKS_OFS_VALUE1, 32'h0000_0120);
    wr(MKS_OFS_STATUS, 32'h1);
    rchk(MKS_OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rchk(MKS_OFS_MASK, 32'h1);
    rchk(MKS_OFS_COLGPIO, 32'h08);
    wr(MKS_OFS_CONFIG, 32'h0);
    key_map <= 36'h0;
  endtask

  // reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_idle();
    t_hold();
    t_rate(MKS_RATE_128, 128);
    t_rate(MKS_RATE_256, 256);
    t_rate(MKS_RATE_512, 512);
    t_scan();
    give_verdict();
  end
endmodule
